// ===== logic/ssp_pkg.sv
`default_nettype none

package ssp_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register byte offsets on the APB slave.
	localparam logic [7:0] SSP_CTRL_OFS = 8'h00;
	localparam logic [7:0] SSP_STAT_OFS = 8'h04;
	localparam logic [7:0] SSP_DATA_OFS = 8'h08;
	localparam logic [7:0] SSP_PDAT_OFS = 8'h0C;
	localparam logic [7:0] SSP_PDIR_OFS = 8'h10;

	////////////////////////////////////////////////////////////////////////////////
	// Field positions.
	localparam int SSP_CTRL_EN_BIT   = 6;
	localparam int SSP_CTRL_MS_BIT   = 4;
	localparam int SSP_STAT_DONE_BIT = 7;
	localparam int SSP_STAT_COL_BIT  = 6;

	// Index of each shared pin inside the three-bit port data and direction fields.
	localparam int SSP_PIN_OUT = 0;
	localparam int SSP_PIN_IN  = 1;
	localparam int SSP_PIN_CLK = 2;
	localparam int SSP_NPINS   = 3;

	////////////////////////////////////////////////////////////////////////////////
	// Reset values.
	localparam logic [2:0] SSP_PDAT_RST = 3'h0;
	localparam logic [2:0] SSP_PDIR_RST = 3'h0;
	localparam logic [7:0] SSP_SR_RST   = 8'h00;

	////////////////////////////////////////////////////////////////////////////////
	// Timing: the master serial clock period, in internal bus cycles.
	localparam int         SSP_SCK_PERIOD_CYC = 4;
	localparam int         SSP_SCK_LOW_CYC    = SSP_SCK_PERIOD_CYC / 2;
	localparam int         SSP_XFER_BITS      = 8;
	localparam logic [2:0] SSP_LAST_BIT       = 3'(SSP_XFER_BITS - 1);

	////////////////////////////////////////////////////////////////////////////////
	// Transfer sequencer states. The four master phases are one bus cycle each.
	typedef enum logic [5:0] {
		ST_IDLE   = 6'b000001,
		ST_M_LOW0 = 6'b000010,
		ST_M_LOW1 = 6'b000100,
		ST_M_HI0  = 6'b001000,
		ST_M_HI1  = 6'b010000,
		ST_S_BUSY = 6'b100000
	} ssp_state_t;

endpackage : ssp_pkg

`default_nettype wire

// ===== logic/ssp_sync2.sv
`timescale 1ns/1ps
`default_nettype none

module ssp_sync2 #(
	parameter int W = 3
) (
	input  wire logic         mclk,
	input  wire logic         nrst,
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);

	logic [W-1:0] meta_q;

	// The first stage feeds only the second stage.
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			meta_q <= '1;
			q      <= '1;
		end
		else
		begin
			meta_q <= d;
			q      <= meta_q;
		end
	end

endmodule : ssp_sync2

`default_nettype wire

// ===== logic/ssp_port.sv
// Functional notes
// - Master mode: writing data register loads byte, starts shifting and clock.
// - Master mode drives clock pin; period is exactly four bus cycles.
// - Serial clock idles high between transfers; polarity fixed.
// - First falling clock edge starts transfer and presents first output bit.
// - Input pin is sampled on every rising clock edge.
// - Transfer is eight bits, complete on the eighth rising edge.
// - Output pin keeps last shifted bit between transfers.
// - Enable bit 6 gives the three pins to the port; clear returns them.
// - Enabling rewrites pin directions for serial use; they persist afterwards.
// - Bit order is a build option, not a register bit.
// - Master and slave registers form one sixteen-bit ring, bytes exchanged.
// - No slave select; slave joins every clocked transfer.
// - No automatic data pin reversal; no multi-master support.
// - Done flag sets on eighth rise; cleared by status read then data access.
// - Collision on data access mid-transfer; cleared by done sequence or re-enable.
// - Clearing enable aborts transfer, resets bit count; reset clears enable.
// - Master select sets clock pin direction, writable anytime, reset clears.
`timescale 1ns/1ps
`default_nettype none

module ssp_port
	import ssp_pkg::*;
#(
	parameter bit MSB_FIRST = 1'b1
) (
	input  wire logic                 mclk,
	input  wire logic                 nrst,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [7:0]           paddr,
	input  wire logic [31:0]          pwdata,
	output var  logic [31:0]          prdata,
	output var  logic                 pready,
	output var  logic                 pslverr,
	input  wire logic [SSP_NPINS-1:0] pin_i,
	output var  logic [SSP_NPINS-1:0] pin_o,
	output var  logic [SSP_NPINS-1:0] pin_oe
);

	////////////////////////////////////////////////////////////////////////////////
	// State.

	typedef struct packed {
		ssp_state_t           st;
		logic [7:0]           sr;
		logic [2:0]           cnt;
		logic                 sck;
		logic                 sdo;
		logic                 en;
		logic                 ms;
		logic                 done;
		logic                 col;
		logic                 armed;
		logic [2:0]           pdat;
		logic [2:0]           pdir;
		logic                 ck_prev;
		logic [SSP_NPINS-1:0] pin_o;
		logic [SSP_NPINS-1:0] pin_oe;
		logic                 pready;
		logic                 pslverr;
		logic [31:0]          prdata;
	} ssp_regs_t;

	localparam ssp_regs_t SSP_REGS_RST = '{
		st:      ST_IDLE,
		sr:      SSP_SR_RST,
		cnt:     3'h0,
		sck:     1'b1,
		sdo:     1'b0,
		en:      1'b0,
		ms:      1'b0,
		done:    1'b0,
		col:     1'b0,
		armed:   1'b0,
		pdat:    SSP_PDAT_RST,
		pdir:    SSP_PDIR_RST,
		ck_prev: 1'b1,
		pin_o:   3'h0,
		pin_oe:  3'h0,
		pready:  1'b0,
		pslverr: 1'b0,
		prdata:  32'h0000_0000
	};

	ssp_regs_t            q;
	ssp_regs_t            d;
	logic [SSP_NPINS-1:0] pin_s;

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers.

	ssp_sync2 #(
		.W (SSP_NPINS)
	) u_sync (
		.mclk (mclk),
		.nrst (nrst),
		.d    (pin_i),
		.q    (pin_s)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Bit order helpers.

	// Bit presented on the output pin for a given shift register value.
	function automatic logic out_bit(input logic [7:0] v);
		out_bit = MSB_FIRST ? v[7] : v[0];
	endfunction : out_bit

	// Received bit enters at the end opposite to the one leaving.
	function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b);
		shift_in = MSB_FIRST ? {v[6:0], b} : {b, v[7:1]};
	endfunction : shift_in

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic.

	always_comb
	begin
		logic       acc_setup;
		logic       acc_done;
		logic       mapped;
		logic       is_data;
		logic       data_acc;
		logic       busy;
		logic       ck_rise;
		logic       ck_fall;
		logic       s_in;
		logic       new_en;
		logic [7:0] sr_n;
		logic [2:0] prd;

		acc_setup = psel & ~penable;
		acc_done  = psel & penable & q.pready;
		mapped    = (paddr == SSP_CTRL_OFS) || (paddr == SSP_STAT_OFS) || (paddr == SSP_DATA_OFS)
		         || (paddr == SSP_PDAT_OFS) || (paddr == SSP_PDIR_OFS);
		is_data   = paddr == SSP_DATA_OFS;
		data_acc  = acc_done & is_data & q.en;
		busy      = q.st != ST_IDLE;
		ck_rise   = ~q.ck_prev & pin_s[SSP_PIN_CLK];
		ck_fall   = q.ck_prev & ~pin_s[SSP_PIN_CLK];
		s_in      = pin_s[SSP_PIN_IN];
		new_en    = pwdata[SSP_CTRL_EN_BIT];
		sr_n      = shift_in(q.sr, s_in);
		prd       = 3'h0;

		d         = q;
		d.pready  = 1'b0;
		d.pslverr = 1'b0;
		d.ck_prev = pin_s[SSP_PIN_CLK];

		// Setup phase: answer is staged so the bus outputs come from flip-flops.
		if (acc_setup)
		begin
			d.pready  = 1'b1;
			d.pslverr = ~mapped;
			d.prdata  = 32'h0000_0000;
			for (int i = 0; i < SSP_NPINS; i++)
			begin
				prd[i] = q.pdir[i] ? q.pdat[i] : pin_s[i];
			end
			case (paddr)
				SSP_CTRL_OFS:
				begin
					d.prdata[SSP_CTRL_EN_BIT] = q.en;
					d.prdata[SSP_CTRL_MS_BIT] = q.ms;
				end
				SSP_STAT_OFS:
				begin
					d.prdata[SSP_STAT_DONE_BIT] = q.done;
					d.prdata[SSP_STAT_COL_BIT]  = q.col;
				end
				SSP_DATA_OFS: d.prdata[7:0] = q.en ? q.sr : 8'h00;
				SSP_PDAT_OFS: d.prdata[2:0] = prd;
				SSP_PDIR_OFS: d.prdata[2:0] = q.pdir;
				default:      d.prdata = 32'h0000_0000;
			endcase
		end

		// Clearing sequences come first so that hardware sets below win.
		if (acc_done && !pwrite && paddr == SSP_STAT_OFS && q.done)
		begin
			d.armed = 1'b1;
		end
		if (data_acc && q.armed)
		begin
			d.done  = 1'b0;
			d.col   = 1'b0;
			d.armed = 1'b0;
		end
		if (data_acc && busy)
		begin
			d.col = 1'b1;
		end

		// Register writes.
		if (acc_done && pwrite && mapped)
		begin
			case (paddr)
				SSP_CTRL_OFS:
				begin
					d.en = new_en;
					d.ms = pwdata[SSP_CTRL_MS_BIT];
					if (q.en && !new_en)
					begin
						d.st  = ST_IDLE;
						d.cnt = 3'h0;
						d.sck = 1'b1;
					end
					if (!q.en && new_en)
					begin
						d.col = 1'b0;
						d.sdo = q.pdat[SSP_PIN_OUT];
					end
				end
				SSP_PDAT_OFS: d.pdat = pwdata[2:0];
				SSP_PDIR_OFS: d.pdir = pwdata[2:0];
				SSP_DATA_OFS:
				begin
					// A write mid-transfer only flags a collision; the shifter is left alone.
					if (q.en && !busy)
					begin
						d.sr = pwdata[7:0];
						if (q.ms)
						begin
							d.st  = ST_M_LOW0;
							d.cnt = 3'h0;
							d.sck = 1'b0;
							d.sdo = out_bit(pwdata[7:0]);
						end
					end
				end
				default:      d.en = d.en;
			endcase
		end

		// Transfer sequencer. An abort written above in this cycle takes priority.
		if (d.en && q.en)
		begin
			case (q.st)
				ST_M_LOW0:
				begin
					d.st = ST_M_LOW1;
				end
				ST_M_LOW1:
				begin
					d.st  = ST_M_HI0;
					d.sck = 1'b1;
				end
				ST_M_HI0:
				begin
					d.st = ST_M_HI1;
				end
				ST_M_HI1:
				begin
					// The synchronised input here shows the pin as it stood at the rising edge.
					d.sr = sr_n;
					if (q.cnt == SSP_LAST_BIT)
					begin
						d.st   = ST_IDLE;
						d.cnt  = 3'h0;
						d.done = 1'b1;
					end
					else
					begin
						d.st  = ST_M_LOW0;
						d.cnt = q.cnt + 3'h1;
						d.sck = 1'b0;
						d.sdo = out_bit(sr_n);
					end
				end
				ST_S_BUSY:
				begin
					if (ck_fall)
					begin
						d.sdo = out_bit(q.sr);
					end
					else if (ck_rise)
					begin
						d.sr = sr_n;
						if (q.cnt == SSP_LAST_BIT)
						begin
							d.st   = ST_IDLE;
							d.cnt  = 3'h0;
							d.done = 1'b1;
						end
						else
						begin
							d.cnt = q.cnt + 3'h1;
						end
					end
				end
				ST_IDLE:
				begin
					// No select input: any falling edge while a slave starts a transfer.
					if (!q.ms && ck_fall && d.st == ST_IDLE)
					begin
						d.st  = ST_S_BUSY;
						d.cnt = 3'h0;
						d.sdo = out_bit(q.sr);
					end
				end
				default:
				begin
					d.st = ST_IDLE;
				end
			endcase
		end

		// While enabled the direction bits follow serial use and stay so afterwards.
		if (d.en)
		begin
			d.pdir[SSP_PIN_OUT] = 1'b1;
			d.pdir[SSP_PIN_IN]  = 1'b0;
			d.pdir[SSP_PIN_CLK] = d.ms;
		end

		// Pin drive. Directions never switch on their own during a transfer.
		if (d.en)
		begin
			d.pin_o[SSP_PIN_OUT]  = d.sdo;
			d.pin_oe[SSP_PIN_OUT] = 1'b1;
			d.pin_o[SSP_PIN_IN]   = q.pdat[SSP_PIN_IN];
			d.pin_oe[SSP_PIN_IN]  = 1'b0;
			d.pin_o[SSP_PIN_CLK]  = d.sck;
			d.pin_oe[SSP_PIN_CLK] = d.ms;
		end
		else
		begin
			d.pin_o  = d.pdat;
			d.pin_oe = d.pdir;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register.

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			q <= SSP_REGS_RST;
		end
		else
		begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs.

	assign prdata  = q.prdata;
	assign pready  = q.pready;
	assign pslverr = q.pslverr;
	assign pin_o   = q.pin_o;
	assign pin_oe  = q.pin_oe;

endmodule : ssp_port

`default_nettype wire

// ===== verif/ssp_peer.sv
`timescale 1ns/1ps
`default_nettype none

module ssp_peer (
	input  wire logic clk_pin,
	input  wire logic din,
	output var  logic dout,
	output var  logic clk_drv
);
	logic [7:0] sr = 8'h00;

	initial dout = 1'b1;
	initial clk_drv = 1'b1;

	// No select line exists, so every edge on the wire moves a bit.
	always @(negedge clk_pin) dout <= sr[7];
	always @(posedge clk_pin) sr <= {sr[6:0], din};

	task automatic load(input logic [7:0] v);
		sr = v;
	endtask : load

	// Eight pulses of 160 ns, slower than the bus/4 ceiling; the clock rests high.
	task automatic run;
		#7;
		repeat (8)
		begin
			clk_drv = 1'b0;
			#80;
			clk_drv = 1'b1;
			#80;
		end
	endtask : run
endmodule : ssp_peer

`default_nettype wire

// ===== verif/ssp_port_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module ssp_port_monitor
	import ssp_pkg::*;
(
	input wire logic        mclk,
	input wire logic        nrst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [2:0]  pin_o,
	input wire logic [2:0]  pin_oe
);
	logic       en_m_q;
	logic       clk_q;
	logic [1:0] hi_q;
	logic [3:0] fall_q;
	wire logic  sck;
	wire logic  acc;
	wire logic  rd_acc;
	wire logic  mapped;
	assign sck = pin_oe[2] & pin_o[2];
	assign acc = psel & penable & pready;
	assign rd_acc = acc & !pwrite;
	assign mapped = paddr inside {SSP_CTRL_OFS, SSP_STAT_OFS, SSP_DATA_OFS, SSP_PDAT_OFS, SSP_PDIR_OFS};

	// hi_q saturates at 3: a frame's high phase is 2 cycles, so 3 means the link is idle.
	always_ff @(posedge mclk or negedge nrst)
		if (!nrst)
		begin
			en_m_q <= 1'b0;
			clk_q <= 1'b0;
			hi_q <= 2'h0;
			fall_q <= 4'h0;
		end
		else
		begin
			if (acc && pwrite && paddr == SSP_CTRL_OFS)
				en_m_q <= pwdata[SSP_CTRL_EN_BIT] & pwdata[SSP_CTRL_MS_BIT];
			clk_q <= sck;
			hi_q <= !sck ? 2'h0 : (hi_q == 2'h3 ? 2'h3 : hi_q + 2'h1);
			fall_q <= !en_m_q ? 4'h0 : (hi_q == 2'h3 ? 4'h0 : fall_q) + {3'h0, clk_q & !sck};
		end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	property p_rdy;
		psel && !penable |=> pready ##1 !pready;
	endproperty
	a_rdy: assert property (p_rdy) else $error("ready timing wrong");
	property p_err;
		rd_acc && !mapped |-> pslverr && prdata == 32'h0;
	endproperty
	a_err: assert property (p_err) else $error("unmapped read not refused");
	property p_stat;
		rd_acc && paddr == SSP_STAT_OFS |-> (prdata & 32'hFFFFFF3F) == 32'h0;
	endproperty
	a_stat: assert property (p_stat) else $error("status spare bits set");
	property p_oe;
		acc && pwrite && paddr == SSP_CTRL_OFS && pwdata[6] && pwdata[4] |-> ##[1:3] pin_oe == 3'h5;
	endproperty
	a_oe: assert property (p_oe) else $error("master pins not set");
	property p_low;
		$fell(pin_o[2]) && pin_oe[2] && en_m_q |=> !pin_o[2] ##1 pin_o[2] [*2];
	endproperty
	a_low: assert property (p_low) else $error("clock period wrong");
	property p_start;
		acc && pwrite && paddr == SSP_DATA_OFS && en_m_q && hi_q == 2'h3 |-> ##[1:3] !pin_o[2];
	endproperty
	a_start: assert property (p_start) else $error("write did not start");
	property p_bits;
		hi_q == 2'h3 && $past(hi_q) == 2'h2 && en_m_q |-> fall_q inside {4'h0, 4'h8};
	endproperty
	a_bits: assert property (p_bits) else $error("frame not eight bits");
	property p_idle;
		en_m_q && hi_q == 2'h3 && !$past(acc && pwrite && paddr == SSP_DATA_OFS) |-> pin_o[2] && pin_oe[2];
	endproperty
	a_idle: assert property (p_idle) else $error("clock not idle high");

	c_frame: cover property (hi_q == 2'h3 && $past(hi_q) == 2'h2 && fall_q == 4'h8);
	c_err: cover property (pslverr);
	c_slave: cover property (!pin_oe[2] && pin_oe[0]);
endmodule : ssp_port_monitor

bind ssp_port ssp_port_monitor mon_u (.mclk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
	.pready, .pslverr, .pin_o, .pin_oe);

`default_nettype wire

// ===== verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import ssp_pkg::*;
	logic        mclk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic        pready, pslverr, rerr, clk_drv, peer_out;
	logic [2:0]  pin_i, pin_o, pin_oe;
	int          bad_count = 0, n_checks = 0, cyc = 0;

	always #10 mclk = ~mclk;
	// An undriven serial output reads high, as through a pull-up.
	assign pin_i = {pin_oe[2] ? pin_o[2] : clk_drv, pin_oe[1] ? pin_o[1] : peer_out, pin_oe[0] ? pin_o[0] : 1'b1};

	ssp_port dut_u (.mclk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.pin_i, .pin_o, .pin_oe);
	ssp_peer peer_u (.clk_pin(pin_i[2]), .din(pin_i[0]), .dout(peer_out), .clk_drv(clk_drv));

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do
			@(posedge mclk);
		while (pready !== 1'b1 && ++n < 20);
		chk(32'(n < 20), 32'h1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rdat, e);
	endtask : rd

	task automatic wait_done;
		int n;
		n = 0;
		do
			apb(1'b0, SSP_STAT_OFS, 32'h0);
		while (rdat[SSP_STAT_DONE_BIT] !== 1'b1 && ++n < 60);
	endtask : wait_done

	always @(posedge mclk)
	begin
		cyc++;
		if (cyc > 20000)
		begin
			bad_count++;
			give_verdict();
		end
	end

	initial
	begin
		repeat (2) @(posedge mclk);
		nrst <= 1'b1;
		rd(SSP_CTRL_OFS, 32'h0);
		rd(SSP_STAT_OFS, 32'h0);
		rd(8'h14, 32'h0);
		chk(32'(rerr), 32'h1);
		apb(1'b1, SSP_PDAT_OFS, 32'h1);
		apb(1'b1, SSP_CTRL_OFS, 32'h10);
		apb(1'b1, SSP_CTRL_OFS, 32'h50);
		rd(SSP_CTRL_OFS, 32'h50);
		chk(32'(pin_oe), 32'h5);
		chk(32'({pin_o[2], pin_o[0]}), 32'h3);
		$display("register test done");
		peer_u.load(8'h3C);
		apb(1'b1, SSP_DATA_OFS, 32'hA4);
		apb(1'b1, SSP_DATA_OFS, 32'hFF);
		wait_done();
		chk(rdat, 32'hC0);
		rd(SSP_DATA_OFS, 32'h3C);
		chk(32'(peer_u.sr), 32'hA4);
		rd(SSP_STAT_OFS, 32'h0);
		chk(32'({pin_o[2], pin_o[0]}), 32'h2);
		$display("master test done");
		apb(1'b1, SSP_CTRL_OFS, 32'h40);
		repeat (3) @(posedge mclk);
		chk(32'(pin_oe), 32'h1);
		apb(1'b1, SSP_DATA_OFS, 32'hC3);
		peer_u.load(8'h5A);
		peer_u.run();
		wait_done();
		chk(rdat, 32'h80);
		rd(SSP_DATA_OFS, 32'h5A);
		chk(32'(peer_u.sr), 32'hC3);
		apb(1'b1, SSP_CTRL_OFS, 32'h0);
		rd(SSP_PDIR_OFS, 32'h1);
		rd(SSP_DATA_OFS, 32'h0);
		$display("slave test done");
		apb(1'b1, SSP_PDAT_OFS, 32'h5);
		rd(SSP_PDAT_OFS, 32'h5);
		apb(1'b1, SSP_CTRL_OFS, 32'h50);
		apb(1'b1, SSP_DATA_OFS, 32'h81);
		apb(1'b1, SSP_DATA_OFS, 32'h00);
		apb(1'b1, SSP_CTRL_OFS, 32'h10);
		repeat (2) @(posedge mclk);
		chk(32'({pin_oe, pin_o}), 32'h2D);
		rd(SSP_STAT_OFS, 32'h40);
		apb(1'b1, SSP_CTRL_OFS, 32'h50);
		repeat (40) @(posedge mclk);
		rd(SSP_STAT_OFS, 32'h0);
		chk(32'({pin_o[2], pin_o[0]}), 32'h3);
		peer_u.load(8'h96);
		apb(1'b1, SSP_DATA_OFS, 32'h69);
		wait_done();
		chk(rdat, 32'h80);
		rd(SSP_DATA_OFS, 32'h96);
		apb(1'b1, SSP_CTRL_OFS, 32'h0);
		rd(SSP_PDIR_OFS, 32'h5);
		$display("abort test done");
		give_verdict();
	end
endmodule : testbench

`default_nettype wire
